// ---- design/glitch_filter.sv ----
/*
 Low-pulse glitch filter for an active-low reset pin. The output goes
 low once the input has been low for FILT_CYC cycles and rises as soon
 as the input is high. Assumes the input is synchronous to clk.
*/
`timescale 1ns/100ps
module glitch_filter
   import pwr_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Pin level and filtered level
   input wire logic pinIn_n,
   output logic filtOut_n
);

   logic [FILT_CW-1:0] lowCnt_ff;
   logic [FILT_CW-1:0] nxt_lowCnt;
   logic filt_ff;
   logic nxt_filt;

   ////////////////////////////////////////////////////////////////////
   // Count consecutive low cycles
   always_comb
   begin
      nxt_lowCnt = lowCnt_ff;
      nxt_filt = filt_ff;
      if (pinIn_n)
      begin
         nxt_lowCnt = '0;
         nxt_filt = 1'b1;
      end
      else if (lowCnt_ff == FILT_CYC - 1'b1)
         nxt_filt = 1'b0;
      else
         nxt_lowCnt = lowCnt_ff + 1'b1;
   end

   // State registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lowCnt_ff <= '0;
         filt_ff <= 1'b1;
      end
      else
      begin
         lowCnt_ff <= nxt_lowCnt;
         filt_ff <= nxt_filt;
      end
   end

   assign filtOut_n = filt_ff;

endmodule

// ---- design/power_domain_reset_sequencer.sv ----
/*
 Power domain clock gating, supply isolation, power-up phase sequencer,
 open-drain warm reset pin control and reset cause flags, with an APB
 register slave. Assumes clk is the oscillator clock, which also serves
 as the peripheral clock, and that all inputs are synchronous to it.
*/
`timescale 1ns/100ps
// Overview of operation
// - Six domains; base domain clocks gated one by one via disable bits
// - Domains two to six each set ON, IDLE or OFF by software
// - IDLE and OFF only stop clocks; no reset, no power removal
// - Low core or io power good isolates core logic and io controls
// - Low io supply asserts internal power-on reset
// - Core supply out of range: async pin high-Z plus power-on reset
// - Supply monitor ignored while in low power mode
// - Phase one: 1024 oscillator cycles oscillator start-up check
// - Phase two: 3650 cycles fuse autoload
// - Then 250 cycles flash pump, then 1460 cycles flash bank
// - CPU reset released after all phases; first fetch at zero
// - Power-on reset pin filtered: short lows ignored, long lows reset
// - Any reset condition pulls warm reset pin low, open drain only
// - Warm reset input filtered against short low pulses
// - Warm reset held 1024 plus 3958 cycles after power-on reset
// - Other reset causes hold warm reset at least 32 cycles
// - Cause flags: power-up bit 15, watchdog 13, debugger 11
// - Cause flags: self-test CPU reset 5, software 4, external 3
// - Oscillator fail global bit 0, PLL slip bits 8 and 9; warm reset
module power_domain_reset_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int POR_HOLD_CYC = WARM_POR_OSC_CYC + WARM_POR_FUSE_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Supply monitor
   input wire logic corePowerGood,
   input wire logic ioPowerGood,
   input wire logic coreOutOfRange,
   input wire logic lowPowerMode,
   // Reset pins
   input wire logic powerOnReset_n,
   input wire logic warmResetIn_n,
   output logic warmResetOut,
   output logic warmResetOe,
   // Reset event inputs, one-cycle pulses
   input wire logic watchdogRst,
   input wire logic debugRst,
   input wire logic selfTestCpuRst,
   input wire logic oscFail,
   input wire logic pllSlip,
   // Clock enables, isolation and reset outputs
   output logic [NUM_BASE_CLKS-1:0] baseClkEn,
   output logic [NUM_SW_DOMAINS-1:0] domClkEn,
   output logic isolate,
   output logic pinHighZ,
   output logic cpuReset_n,
   output logic [31:0] bootAddr
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic porFilt_n, warmFilt_n, warmFiltPrev_ff, monOn, coreFault, porActive;
   seq_state_e seq_ff, nxt_seq;
   logic [PH_CW-1:0] phCnt_ff, nxt_phCnt;
   logic [HOLD_CW-1:0] hold_ff, nxt_hold;
   logic oe_ff, nxt_oe, highZ_ff, nxt_highZ, iso_ff, nxt_iso;
   logic cpuRst_ff, nxt_cpuRst, extReq, swReq, otherReq, phaseEnd;
   logic [2*NUM_SW_DOMAINS-1:0] pdCtrl_ff, nxt_pdCtrl;
   logic [2*NUM_SW_DOMAINS-1:0] pdApplied_ff, nxt_pdApplied;
   logic [2:0] settle_ff, nxt_settle;
   logic [NUM_BASE_CLKS-1:0] cddis_ff, nxt_cddis;
   logic [NUM_SW_DOMAINS-1:0] domOn;
   logic [15:0] exc_ff, nxt_exc, excSet;
   logic [9:0] glb_ff, nxt_glb, glbSet;
   logic wrEn, rdEn, ready_ff, nxt_ready, err_ff, nxt_err, mapped;
   logic [31:0] rdata_ff, nxt_rdata, rdMux;
   // Phase length for the current sequencer state
   function automatic logic [PH_CW-1:0] phaseLen(input seq_state_e s);
      case (s)
         SQ_OSC: phaseLen = OSC_PHASE_CYC;
         SQ_FUSE: phaseLen = FUSE_PHASE_CYC;
         SQ_PUMP: phaseLen = PUMP_PHASE_CYC;
         SQ_BANK: phaseLen = BANK_PHASE_CYC;
         default: phaseLen = OSC_PHASE_CYC;
      endcase
   endfunction

   // Register address decode
   function automatic logic isReg(input logic [AW-1:0] a,
      input logic [AW-1:0] ofs);
      isReg = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin glitch filters
   glitch_filter porFilter (.clk(clk), .arst_n(arst_n),
      .pinIn_n(powerOnReset_n), .filtOut_n(porFilt_n));
   glitch_filter warmFilter (.clk(clk), .arst_n(arst_n),
      .pinIn_n(warmResetIn_n), .filtOut_n(warmFilt_n));

   ////////////////////////////////////////////////////////////////////
   // Supply monitor and internal power-on reset
   assign monOn = !lowPowerMode;
   assign coreFault = coreOutOfRange && monOn;
   assign porActive = !porFilt_n || (monOn && !ioPowerGood)
      || coreFault;

   // Isolation and output high-Z targets
   always_comb
   begin
      nxt_iso = monOn && !(corePowerGood && ioPowerGood);
      nxt_highZ = coreFault;
   end

   // High-Z flop sets without waiting for a clock edge
   always_ff @(posedge clk or negedge arst_n or posedge coreFault)
   begin
      if (!arst_n)
         highZ_ff <= 1'b1;
      else if (coreFault)
         highZ_ff <= 1'b1;
      else
         highZ_ff <= nxt_highZ;
   end

   ////////////////////////////////////////////////////////////////////
   // Power-up phase sequencer
   assign phaseEnd = (phCnt_ff == phaseLen(seq_ff) - 1'b1);
   always_comb
   begin
      nxt_seq = seq_ff;
      nxt_phCnt = '0;
      case (seq_ff)
         SQ_POR: nxt_seq = SQ_OSC;
         SQ_OSC: nxt_seq = phaseEnd ? SQ_FUSE : SQ_OSC;
         SQ_FUSE: nxt_seq = phaseEnd ? SQ_PUMP : SQ_FUSE;
         SQ_PUMP: nxt_seq = phaseEnd ? SQ_BANK : SQ_PUMP;
         SQ_BANK: nxt_seq = phaseEnd ? SQ_RUN : SQ_BANK;
         SQ_RUN: nxt_seq = SQ_RUN;
         default: nxt_seq = SQ_POR;
      endcase
      // Count inside a timed phase, restart at every boundary
      if (nxt_seq == seq_ff && seq_ff != SQ_RUN)
         nxt_phCnt = phCnt_ff + 1'b1;
      if (porActive)
      begin
         nxt_seq = SQ_POR;
         nxt_phCnt = '0;
      end
      nxt_cpuRst = (nxt_seq == SQ_RUN) && !nxt_oe;
   end

   // Sequencer and isolation registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         seq_ff <= SQ_POR;
         phCnt_ff <= '0;
         cpuRst_ff <= 1'b0;
         iso_ff <= 1'b1;
      end
      else
      begin
         seq_ff <= nxt_seq;
         phCnt_ff <= nxt_phCnt;
         cpuRst_ff <= nxt_cpuRst;
         iso_ff <= nxt_iso;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Warm reset pin drive and hold timing
   assign extReq = !warmFilt_n && warmFiltPrev_ff && !oe_ff;
   assign swReq = wrEn && isReg(paddr, OFS_SWRST) && pwdata[SWRST_BIT];
   assign otherReq = watchdogRst || debugRst || selfTestCpuRst
      || oscFail || pllSlip || swReq || extReq;

   always_comb
   begin
      nxt_hold = hold_ff;
      if (porActive)
         nxt_hold = HOLD_CW'(POR_HOLD_CYC);
      else if (otherReq && hold_ff < WARM_OTHER_CYC)
         nxt_hold = WARM_OTHER_CYC;
      else if (hold_ff != '0)
         nxt_hold = hold_ff - 1'b1;
      nxt_oe = (nxt_hold != '0);
   end

   // Warm reset and cause flag registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hold_ff <= HOLD_CW'(POR_HOLD_CYC);
         oe_ff <= 1'b1;
         warmFiltPrev_ff <= 1'b1;
         exc_ff <= EXC_RST_VAL;
         glb_ff <= '0;
      end
      else
      begin
         hold_ff <= nxt_hold;
         oe_ff <= nxt_oe;
         warmFiltPrev_ff <= warmFilt_n;
         exc_ff <= nxt_exc;
         glb_ff <= nxt_glb;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset cause flags, hardware set wins over software clear
   always_comb
   begin
      excSet = '0;
      excSet[EXC_WDOG] = watchdogRst;
      excSet[EXC_DBG] = debugRst;
      excSet[EXC_STC] = selfTestCpuRst;
      excSet[EXC_SW] = swReq;
      excSet[EXC_EXT] = extReq;
      glbSet = '0;
      glbSet[GLB_OSCFAIL] = oscFail;
      glbSet[GLB_SLIP0] = pllSlip;
      glbSet[GLB_SLIP1] = pllSlip;
      nxt_exc = exc_ff;
      nxt_glb = glb_ff;
      if (wrEn && isReg(paddr, OFS_EXCSTAT))
         nxt_exc = exc_ff & ~pwdata[15:0];
      if (wrEn && isReg(paddr, OFS_GLBSTAT))
         nxt_glb = glb_ff & ~pwdata[9:0];
      nxt_exc = nxt_exc | excSet;
      nxt_glb = nxt_glb | glbSet;
      if (porActive)
      begin
         nxt_exc = EXC_RST_VAL;
         nxt_glb = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Domain states and clock gating
   always_comb
   begin
      nxt_pdCtrl = pdCtrl_ff;
      nxt_cddis = cddis_ff;
      nxt_pdApplied = pdApplied_ff;
      nxt_settle = settle_ff;
      if (wrEn && isReg(paddr, OFS_PDCTRL))
      begin
         nxt_pdCtrl = pwdata[2*NUM_SW_DOMAINS-1:0];
         nxt_settle = PD_SETTLE_CYC;
      end
      else if (settle_ff != '0)
      begin
         nxt_settle = settle_ff - 1'b1;
         if (settle_ff == 3'h1)
            nxt_pdApplied = pdCtrl_ff;
      end
      if (wrEn && isReg(paddr, OFS_CDDIS))
         nxt_cddis = pwdata[NUM_BASE_CLKS-1:0];
   end

   // IDLE and OFF both only remove the clock
   generate
      for (genvar d = 0; d < NUM_SW_DOMAINS; d++)
      begin : g_dom
         assign domOn[d] = (pdApplied_ff[2*d +: 2] == PD_ON);
      end
   endgenerate

   // Domain registers and clock enable outputs
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pdCtrl_ff <= '0;
         pdApplied_ff <= '0;
         settle_ff <= '0;
         cddis_ff <= '0;
         baseClkEn <= '1;
         domClkEn <= '1;
         bootAddr <= BOOT_ADDR;
      end
      else
      begin
         pdCtrl_ff <= nxt_pdCtrl;
         pdApplied_ff <= nxt_pdApplied;
         settle_ff <= nxt_settle;
         cddis_ff <= nxt_cddis;
         baseClkEn <= ~cddis_ff;
         domClkEn <= domOn;
         bootAddr <= BOOT_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave, one wait state, writes at the completing edge
   assign wrEn = psel && penable && pwrite && ready_ff;
   assign rdEn = psel && penable && !pwrite && !ready_ff;
   assign mapped = isReg(paddr, OFS_PDCTRL) || isReg(paddr, OFS_CDDIS)
      || isReg(paddr, OFS_STATUS) || isReg(paddr, OFS_EXCSTAT)
      || isReg(paddr, OFS_GLBSTAT) || isReg(paddr, OFS_SWRST);

   // Read data multiplexer
   always_comb
   begin
      rdMux = '0;
      case (1'b1)
         isReg(paddr, OFS_PDCTRL): rdMux[2*NUM_SW_DOMAINS-1:0] = pdCtrl_ff;
         isReg(paddr, OFS_CDDIS): rdMux[NUM_BASE_CLKS-1:0] = cddis_ff;
         isReg(paddr, OFS_STATUS):
         begin
            rdMux[ST_BUSY] = (settle_ff != '0);
            rdMux[ST_DONE] = (seq_ff == SQ_RUN);
            rdMux[ST_PHASE +: 6] = seq_ff;
         end
         isReg(paddr, OFS_EXCSTAT): rdMux[15:0] = exc_ff;
         isReg(paddr, OFS_GLBSTAT): rdMux[9:0] = glb_ff;
         default: rdMux = '0;
      endcase
   end

   // Handshake next values
   always_comb
   begin
      nxt_ready = psel && penable && !ready_ff;
      nxt_rdata = rdEn ? rdMux : rdata_ff;
      nxt_err = nxt_ready ? !mapped : 1'b0;
   end

   // Bus registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ready_ff <= 1'b0;
         rdata_ff <= '0;
         err_ff <= 1'b0;
      end
      else
      begin
         ready_ff <= nxt_ready;
         rdata_ff <= nxt_rdata;
         err_ff <= nxt_err;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops, except warmResetOut which is tied low
   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = err_ff;
   assign warmResetOut = 1'b0;
   assign warmResetOe = oe_ff;
   assign isolate = iso_ff;
   assign pinHighZ = highZ_ff;
   assign cpuReset_n = cpuRst_ff;

endmodule

// ---- include/pwr_seq_pkg.sv ----
/*
 Constants for the power domain and reset sequencer: clock rate, phase
 lengths, filter and hold times, register offsets, field positions and
 state codes. Assumes the sequencer clock is the oscillator clock.
*/
package pwr_seq_pkg;

   // Clock rate
   localparam int CLK_MHZ = 100;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

   // Power-up phase lengths in oscillator cycles
   localparam int PH_CW = 12;
   localparam logic [PH_CW-1:0] OSC_PHASE_CYC = 12'h400;
   localparam logic [PH_CW-1:0] FUSE_PHASE_CYC = 12'hE42;
   localparam logic [PH_CW-1:0] PUMP_PHASE_CYC = 12'h0FA;
   localparam logic [PH_CW-1:0] BANK_PHASE_CYC = 12'h5B4;

   // Pin glitch filter: lows shorter than the minimum are ignored
   localparam int FILT_MIN_NS = 500;
   localparam int FILT_MAX_NS = 2000;
   localparam int FILT_CYC_I = (FILT_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int FILT_CW = 8;
   localparam logic [FILT_CW-1:0] FILT_CYC = FILT_CW'(FILT_CYC_I);

   // Warm reset hold times in clock cycles
   localparam int WARM_POR_OSC_CYC = 1024;
   localparam int WARM_POR_FUSE_CYC = 3958;
   localparam int HOLD_CW = 13;
   localparam logic [HOLD_CW-1:0] WARM_OTHER_CYC = 13'h0020;

   // Domain transition settle time in cycles
   localparam logic [2:0] PD_SETTLE_CYC = 3'h4;

   // Domains
   localparam int NUM_DOMAINS = 6;
   localparam int NUM_SW_DOMAINS = NUM_DOMAINS - 1;
   localparam int NUM_BASE_CLKS = 8;
   localparam logic [1:0] PD_ON = 2'h0;
   localparam logic [1:0] PD_IDLE = 2'h1;
   localparam logic [1:0] PD_OFF = 2'h2;

   // First fetch address after CPU reset release
   localparam logic [31:0] BOOT_ADDR = 32'h00000000;

   // Register byte offsets
   localparam int AW = 8;
   localparam logic [AW-1:0] OFS_PDCTRL = 8'h00;
   localparam logic [AW-1:0] OFS_CDDIS = 8'h04;
   localparam logic [AW-1:0] OFS_STATUS = 8'h08;
   localparam logic [AW-1:0] OFS_EXCSTAT = 8'h0C;
   localparam logic [AW-1:0] OFS_GLBSTAT = 8'h10;
   localparam logic [AW-1:0] OFS_SWRST = 8'h14;

   // Exception status bit positions
   localparam int EXC_POR = 15;
   localparam int EXC_WDOG = 13;
   localparam int EXC_DBG = 11;
   localparam int EXC_STC = 5;
   localparam int EXC_SW = 4;
   localparam int EXC_EXT = 3;
   localparam logic [15:0] EXC_RST_VAL = 16'h8000;

   // Global status bit positions
   localparam int GLB_OSCFAIL = 0;
   localparam int GLB_SLIP0 = 8;
   localparam int GLB_SLIP1 = 9;

   // Status register bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_PHASE = 8;

   // Software reset trigger bit
   localparam int SWRST_BIT = 0;

   // Power-up sequencer states
   typedef enum logic [5:0] {
      SQ_POR = 6'h01,
      SQ_OSC = 6'h02,
      SQ_FUSE = 6'h04,
      SQ_PUMP = 6'h08,
      SQ_BANK = 6'h10,
      SQ_RUN = 6'h20
   } seq_state_e;

endpackage

// ---- tb/power_domain_reset_sequencer_asserts.sv ----
/*
 Port checker for the reset sequencer.
 Assumes a single clock and a pulled-up warm reset wire.
*/
`timescale 1ns/100ps
module pdrs_asserts
   import pwr_seq_pkg::*;
#(
   parameter int POR_HOLD_CYC = 4982
)
(
   // Clock, reset and supply monitor
   input wire logic clk,
   input wire logic arst_n,
   input wire logic corePowerGood,
   input wire logic ioPowerGood,
   input wire logic coreOutOfRange,
   input wire logic lowPowerMode,
   // Reset pins and outputs
   input wire logic warmResetIn_n,
   input wire logic warmResetOut,
   input wire logic warmResetOe,
   input wire logic isolate,
   input wire logic pinHighZ,
   input wire logic cpuReset_n
);
   logic [12:0] oeCnt;
   logic [7:0] lowCnt;
   logic porRun;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   //////////////////////////////
   // Drive length, wire low length, power-on episode
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         oeCnt <= 13'h0000;
         lowCnt <= 8'h00;
         porRun <= 1'b1;
      end
      else
      begin
         oeCnt <= warmResetOe ? oeCnt + {12'h000, ~&oeCnt} : 13'h0000;
         lowCnt <= warmResetIn_n ? 8'h00 : lowCnt + {7'h00, ~&lowCnt};
         porRun <= (!lowPowerMode && (!ioPowerGood || coreOutOfRange))
            || (porRun && warmResetOe);
      end
   end
   oe_low_only_a: assert property
      (warmResetOut == 1'b0)
      else $error("warm reset driven high");
   cpu_release_a: assert property
      ($rose(cpuReset_n) |-> !warmResetOe)
      else $error("cpu released in warm reset");
   isolate_bad_a: assert property
      (!lowPowerMode && !(corePowerGood && ioPowerGood) |=> isolate)
      else $error("no isolation");
   highz_fault_a: assert property
      (!lowPowerMode && coreOutOfRange |=> pinHighZ ##[0:3] warmResetOe)
      else $error("core fault not handled");
   io_low_por_a: assert property
      (!lowPowerMode && !ioPowerGood |-> ##[1:3] !cpuReset_n && warmResetOe)
      else $error("io low without reset");
   lp_quiet_a: assert property
      (lowPowerMode [*2] |-> !isolate && !pinHighZ)
      else $error("monitor active in low power");
   hold_min_a: assert property
      ($fell(warmResetOe) |-> oeCnt >= 13'd32)
      else $error("warm reset too short");
   por_hold_a: assert property
      ($fell(warmResetOe) && porRun |-> oeCnt >= POR_HOLD_CYC - 1)
      else $error("power-on hold too short");
   ext_req_a: assert property
      (lowCnt == 8'd60 |-> warmResetOe)
      else $error("external request missed");
endmodule

bind power_domain_reset_sequencer pdrs_asserts
   #(.POR_HOLD_CYC(POR_HOLD_CYC)) chk (.clk, .arst_n, .corePowerGood,
   .ioPowerGood, .coreOutOfRange, .lowPowerMode, .warmResetIn_n,
   .warmResetOut, .warmResetOe, .isolate, .pinHighZ, .cpuReset_n);

// ---- tb/power_domain_reset_sequencer_test.sv ----
/*
 Self-checking bench for the reset sequencer, with an APB master.
 Assumes a short power-on hold of 200 cycles.
*/
`timescale 1ns/100ps
module power_domain_reset_sequencer_test
   import pwr_seq_pkg::*;
;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, slvErr;
   logic [AW-1:0] paddr;
   logic [7:0] baseClkEn;
   logic [31:0] pwdata, prdata, bootAddr, rdat;
   logic corePowerGood, ioPowerGood, coreOutOfRange, lowPowerMode;
   logic powerOnReset_n, warmResetIn_n, warmResetOut, warmResetOe;
   logic isolate, pinHighZ, cpuReset_n, extPull, porPull;
   logic [4:0] ev, domClkEn;
   int errTotal, checkCount, cyc, waited, oeRun, oeLast;
   power_domain_reset_sequencer #(.POR_HOLD_CYC(200)) DUT (.clk, .arst_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .corePowerGood, .ioPowerGood, .coreOutOfRange,
      .lowPowerMode, .powerOnReset_n, .warmResetIn_n, .warmResetOut,
      .warmResetOe, .watchdogRst(ev[0]), .debugRst(ev[1]),
      .selfTestCpuRst(ev[2]), .oscFail(ev[3]), .pllSlip(ev[4]),
      .baseClkEn, .domClkEn, .isolate, .pinHighZ, .cpuReset_n, .bootAddr);
   reset_board brd (.warmResetOut, .warmResetOe, .warmResetIn_n,
      .powerOnReset_n, .extPull, .porPull);
   // Clock
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   // Cycles since release and length of the last warm reset drive
   always @(posedge clk)
   begin
      cyc <= arst_n ? cyc + 1 : 0;
      oeRun <= warmResetOe ? oeRun + 1 : 0;
      if (!warmResetOe && oeRun != 0)
         oeLast <= oeRun;
   end
   //////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      checkCount++;
      if (g !== e)
      begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; data and error land in rdat and slvErr
   task automatic apb(input logic w, input logic [AW-1:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 20)
         chk("pready", 32'h1, 32'h0);
   endtask
   task automatic waitOe(input logic v, input int lim);
      waited = 0;
      while (warmResetOe !== v && waited < lim)
      begin
         @(posedge clk);
         waited++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////
   // Power-up phases and CPU release
   task automatic t_boot();
      logic [5:0] ph [4];
      int at [4];
      ph = '{SQ_OSC, SQ_FUSE, SQ_PUMP, SQ_BANK};
      at = '{500, 2000, 4800, 5600};
      for (int i = 0; i < 4; i++)
      begin
         while (cyc < at[i])
            @(posedge clk);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk("phase", {18'h0, ph[i], 8'h00}, rdat & 32'h3F00);
      end
      while (cpuReset_n !== 1'b1 && cyc < 7000)
         @(posedge clk);
      chk("release", 32'h1, {31'h0, cyc >= 6384 && cyc <= 6392});
      apb(1'b0, OFS_EXCSTAT, 32'h0);
      chk("power-up flag", 32'h8000, rdat);
      chk("por drive", 32'h1, {31'h0, oeLast >= 200});
      chk("outputs", 32'h0, {isolate, pinHighZ, warmResetOe});
      chk("boot address", BOOT_ADDR, bootAddr);
      $display("boot end");
   endtask
   // Domain states, base clock disables, unmapped address
   task automatic t_domains();
      logic [9:0] pd [4];
      logic [4:0] en [4];
      int n;
      pd = '{10'h155, 10'h2AA, 10'h0E4, 10'h000};
      en = '{5'h00, 5'h00, 5'h11, 5'h1F};
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, OFS_PDCTRL, {22'h0, pd[i]});
         n = 0;
         rdat = 32'h1;
         while (rdat[ST_BUSY] !== 1'b0 && n < 10)
         begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
         end
         repeat (3) @(posedge clk);
         chk("domain clocks", {27'h0, en[i]}, domClkEn);
         chk("no reset", 32'h1, {warmResetOe, cpuReset_n});
      end
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, OFS_CDDIS, i ? 32'hA5 : 32'hFF);
         repeat (2) @(posedge clk);
         chk("base clocks", i ? 32'h5A : 32'h00, baseClkEn);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, slvErr);
      chk("unmapped data", 32'h0, rdat);
      $display("domains end");
   endtask
   // Lows shorter than the filter time on both pins
   task automatic t_glitch();
      for (int i = 0; i < 2; i++)
      begin
         extPull <= (i == 0);
         porPull <= (i == 1);
         repeat (40) @(posedge clk);
         extPull <= 1'b0;
         porPull <= 1'b0;
         repeat (2) @(posedge clk);
         chk("glitch", 32'h1, {warmResetOe, cpuReset_n});
      end
      $display("glitch end");
   endtask
   // Each warm reset cause, its drive length and flag
   task automatic t_causes();
      logic [31:0] exp [7];
      logic [AW-1:0] ofs;
      exp = '{32'hA000, 32'h8800, 32'h8020, 32'h0001, 32'h0300,
         32'h8010, 32'h8008};
      for (int i = 0; i < 7; i++)
      begin
         ofs = (i == 3 || i == 4) ? OFS_GLBSTAT : OFS_EXCSTAT;
         if (i < 5)
         begin
            ev[i] <= 1'b1;
            @(posedge clk);
            ev <= 5'h00;
         end
         else if (i == 5)
            apb(1'b1, OFS_SWRST, 32'h1);
         else
         begin
            extPull <= 1'b1;
            repeat (70) @(posedge clk);
            extPull <= 1'b0;
         end
         waitOe(1'b1, 20);
         waitOe(1'b0, 300);
         @(posedge clk);
         chk("drive length", 32'h1, {31'h0, oeLast >= 32});
         apb(1'b0, ofs, 32'h0);
         chk("cause flag", exp[i], rdat);
         if (i == 6)
            break;
         apb(1'b1, ofs, exp[i] & 32'h7FFF);
         apb(1'b0, ofs, 32'h0);
         chk("flag cleared", exp[i] & 32'h8000, rdat);
      end
      $display("causes end");
   endtask
   // Supply monitor responses, with and without low power mode
   task automatic t_supply();
      corePowerGood <= 1'b0;
      repeat (3) @(posedge clk);
      chk("isolate", 32'h2, {isolate, warmResetOe});
      corePowerGood <= 1'b1;
      lowPowerMode <= 1'b1;
      @(posedge clk);
      ioPowerGood <= 1'b0;
      coreOutOfRange <= 1'b1;
      repeat (4) @(posedge clk);
      chk("monitor off", 32'h0, {isolate, pinHighZ, warmResetOe});
      ioPowerGood <= 1'b1;
      coreOutOfRange <= 1'b0;
      @(posedge clk);
      lowPowerMode <= 1'b0;
      @(posedge clk);
      coreOutOfRange <= 1'b1;
      repeat (3) @(posedge clk);
      chk("core fault", 32'h6, {pinHighZ, warmResetOe, cpuReset_n});
      coreOutOfRange <= 1'b0;
      ioPowerGood <= 1'b0;
      repeat (3) @(posedge clk);
      chk("io low", 32'h2, {warmResetOe, cpuReset_n});
      ioPowerGood <= 1'b1;
      $display("supply end");
   endtask
   // Power-on pin restarts the sequence midway, then a full power-up
   task automatic t_por();
      int t0;
      for (int i = 0; i < 2; i++)
      begin
         porPull <= 1'b1;
         repeat (60) @(posedge clk);
         porPull <= 1'b0;
         t0 = cyc;
         chk("por drive", 32'h2, {warmResetOe, cpuReset_n});
         if (i == 0)
            repeat (2000) @(posedge clk);
      end
      while (cpuReset_n !== 1'b1 && cyc - t0 < 7000)
         @(posedge clk);
      chk("restart", 32'h1, {31'h0, cyc - t0 inside {[6384:6395]}});
      apb(1'b0, OFS_EXCSTAT, 32'h0);
      chk("por flags", 32'h8000, rdat);
      $display("por end");
   endtask
   // Main sequence
   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      {psel, penable, pwrite, coreOutOfRange, lowPowerMode} = 5'h00;
      {extPull, porPull, corePowerGood, ioPowerGood} = 4'h3;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = 5'h00;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      t_boot();
      t_domains();
      t_glitch();
      t_causes();
      t_supply();
      t_por();
      summarize();
   end
   // Watchdog against a hung wait
   initial
   begin
      repeat (40000) @(posedge clk);
      errTotal++;
      summarize();
   end
endmodule

// ---- tb/reset_board.sv ----
/*
 Board side of the reset pins: supervisor on the power-on pin and
 the pulled-up warm reset wire. Assumes only the device's enable and extPull pull.
*/
`timescale 1ns/100ps
module reset_board (
   // Device side
   input wire logic warmResetOut,
   input wire logic warmResetOe,
   output logic warmResetIn_n,
   output logic powerOnReset_n,
   // Supervisor requests
   input wire logic extPull,
   input wire logic porPull
);
   // Pull-up wire, low while any party pulls it
   assign warmResetIn_n = !((warmResetOe && !warmResetOut) || extPull);
   // Supervisor holds the power-on pin high when no request
   assign powerOnReset_n = !porPull;
endmodule
